// ---- verilog/pnd_pkg.sv ----
/*
 * constants for the pattern next-data transfer block: register indices,
 * reset values, field layout and bus-state encoding.
 * assumes a 32-bit classic wishbone bus; byte address = 4 * index.
 */
package pnd_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [27:0] IDX_ENABLE_HIGH = 28'h5fffff0;
    localparam logic [27:0] IDX_TRIGGER_SEL = 28'h5fffff1;
    localparam logic [27:0] IDX_ENABLE_LOW = 28'h5fffff3;
    localparam logic [27:0] IDX_NEXT_HIGH_UPPER = 28'h5fffff4;
    localparam logic [27:0] IDX_NEXT_LOW_UPPER = 28'h5fffff5;
    localparam logic [27:0] IDX_NEXT_HIGH_LOWER = 28'h5fffff6;
    localparam logic [27:0] IDX_NEXT_LOW_GROUP0 = 28'h5fffff7;
    localparam logic [27:0] IDX_OVERLAP_MODE = 28'h5fffff8;
    localparam logic [27:0] IDX_PORT_OUT_DATA = 28'h5fffffa;

    // ************************************************************
    // widths and field layout
    // ************************************************************
    localparam int GROUPS = 4;
    localparam int NIB = 4;
    localparam int PAT_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W = 2;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 29;

    // ************************************************************
    // reset and read values
    // ************************************************************
    localparam logic [7:0] NEXT_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] TRIGGER_RESET = 8'hff;
    localparam logic [3:0] OVERLAP_RESET = 4'h0;
    localparam logic [15:0] PORT_RESET = 16'h0000;
    localparam logic [3:0] RSVD_NIB = 4'hf;
    localparam logic [7:0] RSVD_BYTE = 8'hff;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ************************************************************
    // bus slave states
    // ************************************************************
    typedef enum logic [1:0] {
        PND_IDLE = 2'b01,
        PND_ACK = 2'b10
    } pnd_bus_e;

endpackage : pnd_pkg

// ---- verilog/pnd_pattern_next_data.sv ----
/*
 * next-data buffering and per-bit transfer for a 16-bit timed pattern
 * output: four 4-bit groups, each triggered by a selectable timer channel.
 * assumes compare-match inputs are one-cycle pulses synchronous to clk,
 * and a classic wishbone master that holds its request until ack.
 */
module pnd_pattern_next_data #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [CHANNELS-1:0] cmpMatchA,
    input wire logic [CHANNELS-1:0] cmpMatchB,
    output logic [15:0] patternPins
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic pickChannel(input logic [1:0] sel,
                                         input logic [CHANNELS-1:0] vec);
        pickChannel = vec[sel];
    endfunction : pickChannel

    function automatic logic hitIdx(input logic [31:0] adr, input logic [27:0] idx);
        hitIdx = (adr[pnd_pkg::IDX_MSB:pnd_pkg::IDX_LSB] == idx);
    endfunction : hitIdx

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] nextLow_reg;
    logic [7:0] nextHigh_reg;
    logic [7:0] enableLow_reg;
    logic [7:0] enableHigh_reg;
    logic [7:0] triggerSel_reg;
    logic [3:0] overlapMode_reg;
    logic [15:0] portOut_reg;
    logic [15:0] portOut_next;
    logic [31:0] readData_reg;
    logic [31:0] readData_next;
    pnd_pkg::pnd_bus_e busState_reg;
    pnd_pkg::pnd_bus_e busState_next;

    logic [15:0] enables;
    logic [15:0] nextData;
    logic [15:0] xferMask;
    logic sharedLow;
    logic sharedHigh;
    logic wrStrobe;
    logic wrByte0;
    logic wrByte1;

    assign enables = {enableHigh_reg, enableLow_reg};
    assign nextData = {nextHigh_reg, nextLow_reg};

    // equal codes mean one trigger, so the pair maps as one byte
    assign sharedLow = (triggerSel_reg[3:2] == triggerSel_reg[1:0]);
    assign sharedHigh = (triggerSel_reg[7:6] == triggerSel_reg[5:4]);

    // ************************************************************
    // wishbone classic slave
    // ************************************************************
    // write lands on the edge where ack is sampled high, matching the master
    assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && (busState_reg == pnd_pkg::PND_ACK);
    assign wrByte0 = wrStrobe && wb_sel_i[0];
    assign wrByte1 = wrStrobe && wb_sel_i[1];
    assign wb_ack_o = (busState_reg == pnd_pkg::PND_ACK);
    assign wb_dat_o = readData_reg;

    always_comb begin
        case (busState_reg)
            pnd_pkg::PND_IDLE: begin
                busState_next = (wb_cyc_i && wb_stb_i) ? pnd_pkg::PND_ACK : pnd_pkg::PND_IDLE;
            end
            pnd_pkg::PND_ACK: begin
                busState_next = pnd_pkg::PND_IDLE;
            end
            default: begin
                busState_next = pnd_pkg::PND_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_reg <= pnd_pkg::PND_IDLE;
        end else begin
            busState_reg <= busState_next;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        readData_next = pnd_pkg::UNMAPPED_READ;
        if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_HIGH_UPPER)) begin
            if (sharedHigh) begin
                readData_next[7:0] = nextHigh_reg;
            end else begin
                readData_next[7:0] = {nextHigh_reg[7:4], pnd_pkg::RSVD_NIB};
            end
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_HIGH_LOWER)) begin
            if (sharedHigh) begin
                readData_next[7:0] = pnd_pkg::RSVD_BYTE;
            end else begin
                readData_next[7:0] = {pnd_pkg::RSVD_NIB, nextHigh_reg[3:0]};
            end
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_LOW_UPPER)) begin
            if (sharedLow) begin
                readData_next[7:0] = nextLow_reg;
            end else begin
                readData_next[7:0] = {nextLow_reg[7:4], pnd_pkg::RSVD_NIB};
            end
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_LOW_GROUP0)) begin
            if (sharedLow) begin
                readData_next[7:0] = pnd_pkg::RSVD_BYTE;
            end else begin
                readData_next[7:0] = {pnd_pkg::RSVD_NIB, nextLow_reg[3:0]};
            end
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_ENABLE_LOW)) begin
            readData_next[7:0] = enableLow_reg;
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_ENABLE_HIGH)) begin
            readData_next[7:0] = enableHigh_reg;
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_TRIGGER_SEL)) begin
            readData_next[7:0] = triggerSel_reg;
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_OVERLAP_MODE)) begin
            readData_next[7:0] = {pnd_pkg::RSVD_NIB, overlapMode_reg};
        end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_PORT_OUT_DATA)) begin
            readData_next[15:0] = portOut_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readData_reg <= pnd_pkg::UNMAPPED_READ;
        end else if (busState_reg == pnd_pkg::PND_IDLE) begin
            readData_reg <= readData_next;
        end
    end

    // ************************************************************
    // next-data registers
    // ************************************************************
    // reserved nibbles are simply not stored; software is expected to
    // write ones there, but nothing breaks if it does not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nextHigh_reg <= pnd_pkg::NEXT_RESET;
        end else if (wrByte0) begin
            if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_HIGH_UPPER)) begin
                if (sharedHigh) begin
                    nextHigh_reg <= wb_dat_i[7:0];
                end else begin
                    nextHigh_reg[7:4] <= wb_dat_i[7:4];
                end
            end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_HIGH_LOWER) && !sharedHigh) begin
                nextHigh_reg[3:0] <= wb_dat_i[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nextLow_reg <= pnd_pkg::NEXT_RESET;
        end else if (wrByte0) begin
            if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_LOW_UPPER)) begin
                if (sharedLow) begin
                    nextLow_reg <= wb_dat_i[7:0];
                end else begin
                    nextLow_reg[7:4] <= wb_dat_i[7:4];
                end
            end else if (hitIdx(wb_adr_i, pnd_pkg::IDX_NEXT_LOW_GROUP0) && !sharedLow) begin
                nextLow_reg[3:0] <= wb_dat_i[3:0];
            end
        end
    end

    // ************************************************************
    // enable, trigger select and mode registers
    // ************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enableLow_reg <= pnd_pkg::ENABLE_RESET;
        end else if (wrByte0 && hitIdx(wb_adr_i, pnd_pkg::IDX_ENABLE_LOW)) begin
            enableLow_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enableHigh_reg <= pnd_pkg::ENABLE_RESET;
        end else if (wrByte0 && hitIdx(wb_adr_i, pnd_pkg::IDX_ENABLE_HIGH)) begin
            enableHigh_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            triggerSel_reg <= pnd_pkg::TRIGGER_RESET;
        end else if (wrByte0 && hitIdx(wb_adr_i, pnd_pkg::IDX_TRIGGER_SEL)) begin
            triggerSel_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overlapMode_reg <= pnd_pkg::OVERLAP_RESET;
        end else if (wrByte0 && hitIdx(wb_adr_i, pnd_pkg::IDX_OVERLAP_MODE)) begin
            overlapMode_reg <= wb_dat_i[3:0];
        end
    end

    // ************************************************************
    // per-group transfer masks
    // ************************************************************
    // non-overlap: match A drives rising bits, match B drives falling bits,
    // so the two edges of a pair coincide only if match A and match B fire in the same cycle
    genvar g;
    generate
        for (g = 0; g < pnd_pkg::GROUPS; g++) begin : gen_group
            logic fireA;
            logic fireB;
            logic [3:0] en;
            logic [3:0] nd;
            assign fireA = pickChannel(triggerSel_reg[2*g+1 -: 2], cmpMatchA);
            assign fireB = pickChannel(triggerSel_reg[2*g+1 -: 2], cmpMatchB);
            assign en = enables[g*pnd_pkg::NIB +: pnd_pkg::NIB];
            assign nd = nextData[g*pnd_pkg::NIB +: pnd_pkg::NIB];
            always_comb begin
                if (overlapMode_reg[g]) begin
                    xferMask[g*pnd_pkg::NIB +: pnd_pkg::NIB] =
                        en & ((fireA ? nd : 4'h0) | (fireB ? ~nd : 4'h0));
                end else begin
                    xferMask[g*pnd_pkg::NIB +: pnd_pkg::NIB] = fireA ? en : 4'h0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // port output data
    // ************************************************************
    always_comb begin
        portOut_next = portOut_reg;
        if (hitIdx(wb_adr_i, pnd_pkg::IDX_PORT_OUT_DATA)) begin
            if (wrByte0) begin
                portOut_next[7:0] = (portOut_reg[7:0] & enableLow_reg)
                                  | (wb_dat_i[7:0] & ~enableLow_reg);
            end
            if (wrByte1) begin
                portOut_next[15:8] = (portOut_reg[15:8] & enableHigh_reg)
                                   | (wb_dat_i[15:8] & ~enableHigh_reg);
            end
        end
        // masked bits take next data, the rest keep portOut_next, including any port write
        portOut_next = (portOut_next & ~xferMask) | (nextData & xferMask);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            portOut_reg <= pnd_pkg::PORT_RESET;
        end else begin
            portOut_reg <= portOut_next;
        end
    end

    assign patternPins = portOut_reg;

endmodule : pnd_pattern_next_data

// ---- test/pnd_pattern_next_data_asserts.sv ----
/* checker for the pattern next-data block: bus handshake, reserved reads
   and the causes of pin changes. bound to the top module, sees its ports. */
module pnd_pattern_next_data_asserts #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [CHANNELS-1:0] cmpMatchA,
    input wire logic [CHANNELS-1:0] cmpMatchB,
    input wire logic [15:0] patternPins
);
    logic [27:0] idx;
    logic rdAck;
    logic portWr;
    logic [15:0] enMask_reg;
    assign idx = wb_adr_i[29:2];
    assign rdAck = wb_ack_o && !wb_we_i;
    assign portWr = wb_ack_o && wb_we_i && idx == pnd_pkg::IDX_PORT_OUT_DATA;
    // shadow of the enables, so a pin change can be traced to its cause
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enMask_reg <= 16'h0000;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (idx == pnd_pkg::IDX_ENABLE_LOW) begin
                enMask_reg[7:0] <= wb_dat_i[7:0];
            end
            if (idx == pnd_pkg::IDX_ENABLE_HIGH) begin
                enMask_reg[15:8] <= wb_dat_i[7:0];
            end
        end
    end
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without a request");
    chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_pins_reset: assert property ($past(!arst_n) |-> patternPins == 16'h0000)
        else $error("pins not clear after reset");
    chk_upper_zero: assert property (rdAck && idx != pnd_pkg::IDX_PORT_OUT_DATA
        |-> wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits set");
    chk_group0_rsvd: assert property (
        rdAck && idx == pnd_pkg::IDX_NEXT_LOW_GROUP0 |-> wb_dat_o[7:4] == 4'hf)
        else $error("group 0 address upper nibble not ones");
    chk_high_rsvd: assert property (
        rdAck && idx == pnd_pkg::IDX_NEXT_HIGH_LOWER |-> wb_dat_o[7:4] == 4'hf)
        else $error("second high address upper nibble not ones");
    chk_disabled_hold: assert property (
        ((patternPins ^ $past(patternPins)) & ~$past(enMask_reg)) != 16'h0000
        |-> $past(portWr)) else $error("disabled pin changed without a port write");
    chk_enabled_ro: assert property (
        ((patternPins ^ $past(patternPins)) & $past(enMask_reg)) != 16'h0000
        |-> $past(|cmpMatchA || |cmpMatchB)) else $error("enabled pin changed without match");
endmodule : pnd_pattern_next_data_asserts

bind pnd_pattern_next_data pnd_pattern_next_data_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmpMatchA(cmpMatchA), .cmpMatchB(cmpMatchB), .patternPins(patternPins)
);

// ---- test/pnd_timer_model.sv ----
/* stand-in for the timer's compare-match outputs.
   pulses are one clk cycle wide and launched just after a rising edge. */
module pnd_timer_model #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    output logic [CHANNELS-1:0] cmpMatchA,
    output logic [CHANNELS-1:0] cmpMatchB
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmpMatchA = '0;
        cmpMatchB = '0;
    end
    // a lone match B lets the bench show that ordinary mode ignores it
    task automatic pulse(input int ch, input logic useB);
        @(posedge clk);
        if (useB) begin
            cmpMatchB[ch] <= 1'b1;
        end else begin
            cmpMatchA[ch] <= 1'b1;
        end
        @(posedge clk);
        cmpMatchA <= '0;
        cmpMatchB <= '0;
    endtask : pulse
endmodule : pnd_timer_model

// ---- test/pnd_pattern_next_data_tb.sv ----
/* testbench for the pattern next-data block: register access over wishbone
   and compare-match transfers. assumes the timer model and the checker. */
module pnd_pattern_next_data_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] datW = 32'h0000_0000;
    logic [3:0] sel = 4'h3;
    logic [31:0] datR;
    logic ack;
    logic [3:0] matchA;
    logic [3:0] matchB;
    logic [15:0] pins;
    int errCount = 0;
    int numChecks = 0;

    always #25 clk = ~clk;

    pnd_pattern_next_data #(.CHANNELS(4)) dut (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack),
        .cmpMatchA(matchA), .cmpMatchB(matchB), .patternPins(pins)
    );
    pnd_timer_model #(.CHANNELS(4)) tmr (.clk(clk), .cmpMatchA(matchA), .cmpMatchB(matchB));

    task automatic results();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            errCount++;
        end
    endtask : check

    // request held until ack is sampled high; only the watchdog ends a hung wait
    task automatic wb(input logic w, input logic [27:0] idx, input logic [15:0] d,
                      output logic [15:0] q);
        q = 16'hxxxx;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        datW <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datR[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [27:0] idx, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr

    task automatic rdChk(input logic [27:0] idx, input logic [15:0] exp);
        logic [15:0] q;
        wb(1'b0, idx, 16'h0000, q);
        check(q, exp);
    endtask : rdChk

    task automatic fire(input int ch, input logic useB, input logic [15:0] exp);
        tmr.pulse(ch, useB);
        @(negedge clk);
        check(pins, exp);
    endtask : fire

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rdChk(pnd_pkg::IDX_ENABLE_HIGH, 16'h0000);
        rdChk(pnd_pkg::IDX_ENABLE_LOW, 16'h0000);
        rdChk(pnd_pkg::IDX_TRIGGER_SEL, 16'h00ff);
        rdChk(pnd_pkg::IDX_OVERLAP_MODE, 16'h00f0);
        rdChk(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h0000);
        rdChk(pnd_pkg::IDX_NEXT_HIGH_LOWER, 16'h00ff);
        rdChk(pnd_pkg::IDX_NEXT_LOW_GROUP0, 16'h00ff);
        rdChk(28'h0000004, 16'h0000);
        wr(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h00a5);
        rdChk(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h00a5);
        wr(pnd_pkg::IDX_NEXT_LOW_UPPER, 16'h003c);
        rdChk(pnd_pkg::IDX_NEXT_LOW_UPPER, 16'h003c);
        wr(pnd_pkg::IDX_ENABLE_HIGH, 16'h00f0);
        wr(pnd_pkg::IDX_ENABLE_LOW, 16'h000f);
        rdChk(pnd_pkg::IDX_ENABLE_HIGH, 16'h00f0);
        wr(pnd_pkg::IDX_PORT_OUT_DATA, 16'hffff);
        rdChk(pnd_pkg::IDX_PORT_OUT_DATA, 16'h0ff0);
        fire(2, 1'b0, 16'h0ff0);
        fire(3, 1'b1, 16'h0ff0);
        fire(3, 1'b0, 16'haffc);
        // groups 3/2 on channels 1/2, groups 1/0 still on channel 3
        wr(pnd_pkg::IDX_TRIGGER_SEL, 16'h006f);
        rdChk(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h00af);
        rdChk(pnd_pkg::IDX_NEXT_HIGH_LOWER, 16'h00f5);
        wr(pnd_pkg::IDX_NEXT_HIGH_LOWER, 16'h00f9);
        wr(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h005f);
        wr(pnd_pkg::IDX_ENABLE_HIGH, 16'h00ff);
        fire(2, 1'b0, 16'ha9fc);
        fire(1, 1'b0, 16'h59fc);
        wr(pnd_pkg::IDX_TRIGGER_SEL, 16'h0064);
        rdChk(pnd_pkg::IDX_NEXT_LOW_GROUP0, 16'h00fc);
        rdChk(pnd_pkg::IDX_NEXT_LOW_UPPER, 16'h003f);
        wr(pnd_pkg::IDX_NEXT_LOW_GROUP0, 16'h00f7);
        wr(pnd_pkg::IDX_ENABLE_LOW, 16'h00ff);
        fire(0, 1'b0, 16'h59f7);
        fire(1, 1'b0, 16'h5937);
        rdChk(pnd_pkg::IDX_PORT_OUT_DATA, 16'h5937);
        // group 3 non-overlap: match B clears the zero bits, match A sets the ones
        wr(pnd_pkg::IDX_OVERLAP_MODE, 16'h00f8);
        rdChk(pnd_pkg::IDX_OVERLAP_MODE, 16'h00f8);
        wr(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h00af);
        fire(1, 1'b1, 16'h0937);
        fire(1, 1'b0, 16'ha937);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rdChk(pnd_pkg::IDX_NEXT_HIGH_UPPER, 16'h0000);
        rdChk(pnd_pkg::IDX_ENABLE_LOW, 16'h0000);
        results();
    end

    // the sequence needs under two hundred cycles; this span is far beyond it
    initial begin
        #(3000 * 50);
        errCount++;
        results();
    end
endmodule : pnd_pattern_next_data_tb
